/* ea_pkg.sv */
// ****************************************************************
// shared constants and types for effective-address generation
// ****************************************************************
package ea_pkg;

    // addressing mode announced by the sequencer with each instruction
    typedef enum logic [2:0] {
        MODE_INHERENT,
        MODE_IMMEDIATE,
        MODE_EXTENDED,
        MODE_DIRECT,
        MODE_REGISTER,
        MODE_INDEXED
    } mode_type;

    // indexed variation decoded from the postbyte
    typedef enum logic [3:0] {
        K_ZERO,
        K_OFF5,
        K_OFF8,
        K_OFF16,
        K_ACC_A,
        K_ACC_B,
        K_ACC_D,
        K_INC,
        K_DEC,
        K_EXT,
        K_BAD
    } kind_type;

    // sequencing states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_POST,
        ST_ARG,
        ST_CALC,
        ST_IND_HI,
        ST_IND_LO
    } st_type;

    // postbyte field positions
    localparam int POST_MODE_BIT = 7;
    localparam int POST_IND_BIT  = 4;
    localparam int POST_SEL_HI   = 6;
    localparam int POST_SEL_LO   = 5;

    // low-nibble codes of the indexed family (bit 7 set)
    localparam logic [3:0] CODE_INC1  = 4'h0;
    localparam logic [3:0] CODE_INC2  = 4'h1;
    localparam logic [3:0] CODE_DEC1  = 4'h2;
    localparam logic [3:0] CODE_DEC2  = 4'h3;
    localparam logic [3:0] CODE_ZERO  = 4'h4;
    localparam logic [3:0] CODE_ACC_B = 4'h5;
    localparam logic [3:0] CODE_ACC_A = 4'h6;
    localparam logic [3:0] CODE_OFF8  = 4'h8;
    localparam logic [3:0] CODE_OFF16 = 4'h9;
    localparam logic [3:0] CODE_ACC_D = 4'hB;
    localparam logic [3:0] CODE_PC8   = 4'hC;
    localparam logic [3:0] CODE_PC16  = 4'hD;
    localparam logic [7:0] EXT_IND_POST = 8'h9F;

    // reset value of the page base register
    localparam logic [7:0] PAGE_RESET = 8'h00;
    // address steps
    localparam logic [15:0] STEP_ONE = 16'h0001;
    localparam logic [15:0] STEP_TWO = 16'h0002;

endpackage

/* idx_decoder.sv */
`timescale 1ns/100ps
// ****************************************************************
// indexed postbyte decoder
// ****************************************************************
module idx_decoder (
    // postbyte in
    input  wire logic [7:0]       post,
    // decoded fields
    output ea_pkg::kind_type      kind,
    output logic       [1:0]      sel,
    output logic                  use_pc,
    output logic                  indirect,
    output logic                  step2,
    output logic       [1:0]      arg_bytes
);
    import ea_pkg::*;

    wire       long_form = post[POST_MODE_BIT];
    wire [3:0] code      = post[3:0];

    // variation from the low nibble; bit 4 is the offset sign in short form
    assign kind = !long_form               ? K_OFF5  :
                  (code == CODE_INC1)      ? K_INC   :
                  (code == CODE_INC2)      ? K_INC   :
                  (code == CODE_DEC1)      ? K_DEC   :
                  (code == CODE_DEC2)      ? K_DEC   :
                  (code == CODE_ZERO)      ? K_ZERO  :
                  (code == CODE_ACC_B)     ? K_ACC_B :
                  (code == CODE_ACC_A)     ? K_ACC_A :
                  (code == CODE_OFF8)      ? K_OFF8  :
                  (code == CODE_PC8)       ? K_OFF8  :
                  (code == CODE_OFF16)     ? K_OFF16 :
                  (code == CODE_PC16)      ? K_OFF16 :
                  (code == CODE_ACC_D)     ? K_ACC_D :
                  (post == EXT_IND_POST)   ? K_EXT   : K_BAD;

    // pointer field, ignored by the caller when the program counter is base
    assign sel      = post[POST_SEL_HI:POST_SEL_LO];
    assign use_pc   = long_form && (code == CODE_PC8 || code == CODE_PC16);
    // indirection flag only exists in the long form
    assign indirect = long_form && post[POST_IND_BIT];
    assign step2    = (code == CODE_INC2) || (code == CODE_DEC2);

    // offset bytes that follow the postbyte
    assign arg_bytes = (kind == K_OFF8)                     ? 2'd1 :
                       (kind == K_OFF16 || kind == K_EXT)   ? 2'd2 : 2'd0;

endmodule

/* effective_address_generator.sv */
`timescale 1ns/100ps
module effective_address_generator (
    // clock, reset, enable
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             ce,
    // instruction sequencer
    input  wire logic             start,
    input  wire ea_pkg::mode_type mode,
    input  wire logic             wide,
    input  wire logic [15:0]      pc_in,
    output logic                  busy,
    output logic                  done,
    output logic      [15:0]      ea,
    output logic      [15:0]      pc_next,
    output logic      [7:0]       reg_select,
    // processor registers
    input  wire logic [15:0]      ptr_one,
    input  wire logic [15:0]      ptr_two,
    input  wire logic [15:0]      ptr_three,
    input  wire logic [15:0]      ptr_four,
    input  wire logic [7:0]       first_accumulator,
    input  wire logic [7:0]       second_accumulator,
    input  wire logic             page_write,
    input  wire logic [7:0]       page_wdata,
    output logic      [7:0]       page_base_register,
    // pointer write-back for auto increment and decrement
    output logic                  ptr_we,
    output logic      [1:0]       ptr_sel,
    output logic      [15:0]      ptr_wdata,
    // bus fetch unit
    output logic                  fetch_req,
    output logic      [15:0]      fetch_addr,
    input  wire logic             fetch_ack,
    input  wire logic [7:0]       fetch_data
);
    import ea_pkg::*;

    // ****************************************************************
    // state
    // ****************************************************************
    st_type      state_reg, state_next;
    mode_type    mode_reg,  mode_next;
    logic [15:0] addr_reg,  addr_next;
    logic [15:0] arg_reg,   arg_next;
    logic [1:0]  cnt_reg,   cnt_next;
    logic [7:0]  post_reg,  post_next;
    logic [15:0] ea_reg,    ea_next;
    logic [15:0] pcn_reg,   pcn_next;
    logic [7:0]  rsel_reg,  rsel_next;
    logic        done_reg,  done_next;
    logic        we_reg,    we_next;
    logic [1:0]  wsel_reg,  wsel_next;
    logic [15:0] wdata_reg, wdata_next;
    logic [7:0]  page_reg;

    // ****************************************************************
    // postbyte decode
    // ****************************************************************
    kind_type    dec_kind;
    logic [1:0]  dec_sel;
    logic        dec_pc;
    logic        dec_ind;
    logic        dec_step2;
    logic [1:0]  dec_bytes;

    // the byte arriving in the postbyte cycle is decoded before it is held
    wire [7:0] dec_post = (state_reg == ST_POST) ? fetch_data : post_reg;

    idx_decoder u_dec (
        .post      (dec_post),
        .kind      (dec_kind),
        .sel       (dec_sel),
        .use_pc    (dec_pc),
        .indirect  (dec_ind),
        .step2     (dec_step2),
        .arg_bytes (dec_bytes)
    );

    // ****************************************************************
    // address arithmetic
    // ****************************************************************
    // pointer field mapping
    wire [15:0] sel_ptr = (dec_sel == 2'b00) ? ptr_one   :
                          (dec_sel == 2'b01) ? ptr_two   :
                          (dec_sel == 2'b10) ? ptr_three : ptr_four;

    // program counter base, pointer field ignored
    // addr_reg has already passed the offset bytes when the sum is formed
    wire [15:0] base = (dec_kind == K_EXT) ? 16'h0000 :
                       dec_pc              ? addr_reg : sel_ptr;

    wire [15:0] step     = dec_step2 ? STEP_TWO : STEP_ONE;
    wire [15:0] neg_step = 16'h0000 - step;

    wire [15:0] offset =
        (dec_kind == K_OFF5)  ? {{11{post_reg[4]}}, post_reg[4:0]}           :
        (dec_kind == K_OFF8)  ? {{8{arg_reg[7]}}, arg_reg[7:0]}              :
        (dec_kind == K_OFF16) ? arg_reg                                      :
        (dec_kind == K_EXT)   ? arg_reg                                      :
        (dec_kind == K_ACC_A) ? {{8{first_accumulator[7]}}, first_accumulator} :
        (dec_kind == K_ACC_B) ? {{8{second_accumulator[7]}}, second_accumulator} :
        (dec_kind == K_ACC_D) ? {first_accumulator, second_accumulator}      :
        (dec_kind == K_DEC)   ? neg_step                                     : 16'h0000;

    // sixteen-bit wrap, undefined codes fall through harmlessly
    wire [15:0] idx_ea = base + offset;

    // page base joined with low byte
    wire [15:0] calc_ea = (mode_reg == MODE_EXTENDED) ? arg_reg :
                          (mode_reg == MODE_DIRECT)   ? {page_reg, arg_reg[7:0]} : idx_ea;

    // post-increment value, decrement reuses the pre-decremented address
    wire [15:0] ptr_mod  = (dec_kind == K_INC) ? sel_ptr + step : idx_ea;
    wire        auto_mod = (dec_kind == K_INC) || (dec_kind == K_DEC);

    wire [15:0] addr_inc = addr_reg + STEP_ONE;
    wire [15:0] imm_end  = pc_in + (wide ? STEP_TWO : STEP_ONE);

    // ****************************************************************
    // sequencing
    // ****************************************************************
    // one fetch outstanding at a time; a byte is taken only on ack with ce high
    always_comb begin
        state_next = state_reg;
        mode_next  = mode_reg;
        addr_next  = addr_reg;
        arg_next   = arg_reg;
        cnt_next   = cnt_reg;
        post_next  = post_reg;
        ea_next    = ea_reg;
        pcn_next   = pcn_reg;
        rsel_next  = rsel_reg;
        done_next  = 1'b0;
        we_next    = 1'b0;
        wsel_next  = wsel_reg;
        wdata_next = wdata_reg;
        case (state_reg)
            ST_IDLE: begin
                if (start) begin
                    mode_next = mode;
                    addr_next = pc_in;
                    arg_next  = 16'h0000;
                    if (mode == MODE_INHERENT) begin
                        ea_next   = 16'h0000;
                        pcn_next  = pc_in;
                        done_next = 1'b1;
                    // operand sits right after the opcode
                    end else if (mode == MODE_IMMEDIATE) begin
                        ea_next   = pc_in;
                        pcn_next  = imm_end;
                        done_next = 1'b1;
                    end else if (mode == MODE_EXTENDED) begin
                        cnt_next   = 2'd2;
                        state_next = ST_ARG;
                    end else if (mode == MODE_DIRECT) begin
                        cnt_next   = 2'd1;
                        state_next = ST_ARG;
                    end else begin
                        state_next = ST_POST;
                    end
                end
            end
            ST_POST: begin
                if (fetch_ack) begin
                    post_next = fetch_data;
                    addr_next = addr_inc;
                    if (mode_reg == MODE_REGISTER) begin
                        rsel_next  = fetch_data;
                        pcn_next   = addr_inc;
                        done_next  = 1'b1;
                        state_next = ST_IDLE;
                    end else if (dec_bytes == 2'd0) begin
                        state_next = ST_CALC;
                    end else begin
                        cnt_next   = dec_bytes;
                        state_next = ST_ARG;
                    end
                end
            end
            ST_ARG: begin
                // high byte comes first, so shift left as bytes arrive
                if (fetch_ack) begin
                    arg_next  = {arg_reg[7:0], fetch_data};
                    addr_next = addr_inc;
                    cnt_next  = cnt_reg - 2'd1;
                    if (cnt_reg == 2'd1) begin
                        state_next = ST_CALC;
                    end
                end
            end
            ST_CALC: begin
                pcn_next = addr_reg;
                // only the auto modes write a pointer back
                if (mode_reg == MODE_INDEXED && auto_mod) begin
                    we_next    = 1'b1;
                    wsel_next  = dec_sel;
                    wdata_next = ptr_mod;
                end
                // extended indirect continues through the pointer
                // indirect word fetch at the computed address
                if (mode_reg == MODE_INDEXED && dec_ind) begin
                    addr_next  = calc_ea;
                    state_next = ST_IND_HI;
                end else begin
                    ea_next    = calc_ea;
                    done_next  = 1'b1;
                    state_next = ST_IDLE;
                end
            end
            ST_IND_HI: begin
                if (fetch_ack) begin
                    arg_next   = {fetch_data, arg_reg[7:0]};
                    addr_next  = addr_inc;
                    state_next = ST_IND_LO;
                end
            end
            ST_IND_LO: begin
                if (fetch_ack) begin
                    ea_next    = {arg_reg[15:8], fetch_data};
                    done_next  = 1'b1;
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // reset takes priority over the enable so a frozen core still clears
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            mode_reg  <= MODE_INHERENT;
            addr_reg  <= 16'h0000;
            arg_reg   <= 16'h0000;
            cnt_reg   <= 2'd0;
            post_reg  <= 8'h00;
            ea_reg    <= 16'h0000;
            pcn_reg   <= 16'h0000;
            rsel_reg  <= 8'h00;
            done_reg  <= 1'b0;
            we_reg    <= 1'b0;
            wsel_reg  <= 2'b00;
            wdata_reg <= 16'h0000;
        end else if (ce) begin
            state_reg <= state_next;
            mode_reg  <= mode_next;
            addr_reg  <= addr_next;
            arg_reg   <= arg_next;
            cnt_reg   <= cnt_next;
            post_reg  <= post_next;
            ea_reg    <= ea_next;
            pcn_reg   <= pcn_next;
            rsel_reg  <= rsel_next;
            done_reg  <= done_next;
            we_reg    <= we_next;
            wsel_reg  <= wsel_next;
            wdata_reg <= wdata_next;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            page_reg <= PAGE_RESET;
        end else if (ce && page_write) begin
            page_reg <= page_wdata;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign fetch_req  = (state_reg == ST_POST) || (state_reg == ST_ARG) ||
                        (state_reg == ST_IND_HI) || (state_reg == ST_IND_LO);
    assign busy       = (state_reg != ST_IDLE);
    assign fetch_addr = addr_reg;
    assign done       = done_reg;
    assign ea         = ea_reg;
    assign pc_next    = pcn_reg;
    assign reg_select = rsel_reg;
    assign ptr_we     = we_reg;
    assign ptr_sel    = wsel_reg;
    assign ptr_wdata  = wdata_reg;
    assign page_base_register = page_reg;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    wire start_ok = ce && start && (state_reg == ST_IDLE);

    a_inherent_no_fetch: assert property (
        start_ok && mode == MODE_INHERENT |=> done && !fetch_req && pc_next == $past(pc_in))
        else $error("inherent mode fetched or missed done");

    a_immediate_operand: assert property (
        start_ok && mode == MODE_IMMEDIATE |=> done && ea == $past(pc_in)
            && pc_next == $past(pc_in) + ($past(wide) ? STEP_TWO : STEP_ONE))
        else $error("immediate operand address wrong");

    a_ext_indirect_ptr: assert property (
        ce && state_reg == ST_CALC && mode_reg == MODE_INDEXED && post_reg == EXT_IND_POST
            |=> state_reg == ST_IND_HI && fetch_addr == $past(arg_reg))
        else $error("extended indirect pointer not used");

    a_direct_page_join: assert property (
        ce && state_reg == ST_CALC && mode_reg == MODE_DIRECT
            |=> done && ea[15:8] == $past(page_reg) && ea[7:0] == $past(arg_reg[7:0]))
        else $error("direct address not joined with page base");

    a_page_base_reset: assert property (
        $past(rst) |-> page_reg == PAGE_RESET)
        else $error("page base not cleared by reset");

    a_register_selector: assert property (
        ce && state_reg == ST_POST && mode_reg == MODE_REGISTER && fetch_ack
            |=> done && reg_select == $past(fetch_data))
        else $error("register selector not passed on");

    a_five_bit_offset: assert property (
        ce && state_reg == ST_CALC && mode_reg == MODE_INDEXED && !post_reg[7]
            |=> ea == $past(sel_ptr) + {{11{$past(post_reg[4])}}, $past(post_reg[4:0])})
        else $error("five-bit offset sum wrong");

    a_auto_inc_step: assert property (
        ce && state_reg == ST_CALC && mode_reg == MODE_INDEXED && dec_kind == K_INC
            |=> ptr_we && ptr_wdata == $past(sel_ptr) + ($past(dec_step2) ? STEP_TWO : STEP_ONE))
        else $error("auto increment write-back wrong");

    a_indirect_word: assert property (
        ce && state_reg == ST_IND_LO && fetch_ack
            |=> done && ea == {$past(arg_reg[15:8]), $past(fetch_data)})
        else $error("indirect word not used as address");

    c_immediate: cover property (start_ok && mode == MODE_IMMEDIATE);
    c_register:  cover property (ce && state_reg == ST_POST && mode_reg == MODE_REGISTER && fetch_ack);
    c_indirect:  cover property (ce && state_reg == ST_IND_LO && fetch_ack);
    c_auto_mod:  cover property (ptr_we);

endmodule

/* fetch_partner.sv */
`timescale 1ns/100ps
// ****
// memory behind the fetch port
// ****
module fetch_partner (
    // clock and wait cycles before each byte
    input  wire logic        clk,
    input  wire logic [1:0]  slow,
    // fetch port
    input  wire logic        fetch_req,
    input  wire logic [15:0] fetch_addr,
    output logic             fetch_ack,
    output logic      [7:0]  fetch_data
);
    logic [7:0] mem [0:65535];
    int         given = 0;
    int         waited = 0;
    initial fetch_ack = 1'b0;
    initial fetch_data = 8'h00;
    // answer off the sampling edge; an idle data line toggles so no stale byte passes
    always @(negedge clk) begin
        if (fetch_req && waited >= slow) begin
            fetch_ack  <= 1'b1;
            fetch_data <= mem[fetch_addr];
            given      <= given + 1;
            waited     <= 0;
        end else begin
            fetch_ack  <= 1'b0;
            fetch_data <= ~fetch_data;
            waited     <= fetch_req ? waited + 1 : 0;
        end
    end
endmodule

/* effective_address_generator_bench.sv */
`timescale 1ns/100ps
// ****
// bench with a behavioural address model
// ****
module effective_address_generator_bench;
    import ea_pkg::*;
    logic        clk, rst, ce, start, wide, busy, done, page_write, ptr_we, fetch_req, fetch_ack;
    mode_type    mode;
    logic [15:0] pc_in, ea, pc_next, ptr_wdata, fetch_addr;
    logic [15:0] ptr [4];
    logic [7:0]  acc_a, acc_b, page_wdata, page_base_register, reg_select, fetch_data, page;
    logic [1:0]  ptr_sel, slow;
    logic [31:0] seed = 32'h000020AF;
    logic [3:0]  lows [14] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hB,
                               4'hC, 4'hD, 4'h0, 4'h0};
    int          miscompares = 0;
    int          tests_run = 0;
    effective_address_generator uut (.clk, .rst, .ce, .start, .mode, .wide, .pc_in, .busy,
        .done, .ea, .pc_next, .reg_select, .ptr_one(ptr[0]), .ptr_two(ptr[1]),
        .ptr_three(ptr[2]), .ptr_four(ptr[3]), .first_accumulator(acc_a),
        .second_accumulator(acc_b), .page_write, .page_wdata, .page_base_register, .ptr_we,
        .ptr_sel, .ptr_wdata, .fetch_req, .fetch_addr, .fetch_ack, .fetch_data);
    fetch_partner partner (.clk, .slow, .fetch_req, .fetch_addr, .fetch_ack, .fetch_data);
    // clock and a watchdog sized well beyond the expected run
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #400000;
        miscompares++;
        finish_test();
    end
    // stimulus helpers and the reference model
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [15:0] m16(input logic [15:0] a);
        return {partner.mem[a], partner.mem[a + 16'h0001]};
    endfunction
    function automatic logic [15:0] sx(input logic [7:0] b);
        return {{8{b[7]}}, b};
    endfunction
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic set_page(input logic [7:0] v);
        start = 1'b0;
        page_write = 1'b1;
        page_wdata = v;
        @(negedge clk);
        page_write = 1'b0;
        page = v;
        @(negedge clk);
        chk("page base", {8'h00, v}, {8'h00, page_base_register});
    endtask
    // start is left high so the next request can follow in the done cycle
    task automatic op(input mode_type md, input logic [15:0] p, input logic w);
        logic [15:0] e, pn, r, wd, t, wv;
        logic [7:0]  pb;
        logic [1:0]  ws;
        int          nf, wb, n, g0, wbn, bn;
        pb = partner.mem[p];
        r = ptr[pb[6:5]];
        e = 16'h0000;
        pn = p + STEP_ONE;
        {nf, wb, n, wbn, bn} = {32'd1, 32'd0, 32'd0, 32'd0, 32'd0};
        case (md)
            MODE_INHERENT: {pn, nf} = {p, 32'd0};
            MODE_IMMEDIATE: {e, pn, nf} = {p, p + (w ? STEP_TWO : STEP_ONE), 32'd0};
            MODE_EXTENDED: {e, pn, nf} = {m16(p), p + STEP_TWO, 32'd2};
            MODE_DIRECT, MODE_REGISTER: e = {page, pb};
            default: begin
                if (!pb[POST_MODE_BIT]) e = r + {{11{pb[4]}}, pb[4:0]};
                else begin
                    case (pb[3:0])
                        CODE_INC1, CODE_INC2: {e, wb, wd} = {r, 32'd1, r + STEP_ONE + pb[0]};
                        CODE_DEC1, CODE_DEC2: e = r - STEP_ONE - pb[0];
                        CODE_ACC_B: e = r + sx(acc_b);
                        CODE_ACC_A: e = r + sx(acc_a);
                        CODE_ACC_D: e = r + {acc_a, acc_b};
                        CODE_OFF8, CODE_OFF16, CODE_PC8, CODE_PC16: begin
                            t = pb[0] ? m16(pn) : sx(partner.mem[pn]);
                            pn = pn + STEP_ONE + pb[0];
                            nf = nf + 1 + pb[0];
                            e = (pb[2] ? pn : r) + t;
                        end
                        EXT_IND_POST[3:0]: {e, pn, nf} = {m16(pn), pn + STEP_TWO, nf + 2};
                        default: e = r;
                    endcase
                    if (pb[3:1] == 3'h1) {wb, wd} = {32'd1, e};
                    if (pb[POST_IND_BIT]) {e, nf} = {m16(e), nf + 2};
                end
            end
        endcase
        g0 = partner.given;
        mode = md;
        {pc_in, wide, start} = {p, w, 1'b1};
        do begin
            @(negedge clk);
            n++;
            if (busy === 1'b1) bn++;
            if (ptr_we === 1'b1) {wbn, ws, wv} = {wbn + 1, ptr_sel, ptr_wdata};
        end while (done !== 1'b1 && n < 60);
        chk("done", 16'h0001, {15'h0000, done});
        if (md == MODE_REGISTER) chk("selector", {8'h00, pb}, {8'h00, reg_select});
        else chk("address", e, ea);
        chk("next pc", pn, pc_next);
        chk("fetches", 16'(nf), 16'(partner.given - g0));
        chk("write-backs", 16'(wb), 16'(wbn));
        if (wb == 1) chk("pointer select", {14'h0000, pb[6:5]}, {14'h0000, ws});
        if (wb == 1) chk("new pointer", wd, wv);
        if (md < MODE_EXTENDED) chk("latency", 16'h0001, 16'(n));
        chk("busy cycles", 16'(n - 1), 16'(bn));
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // reset, then plain modes, then the indexed family with every defined postbyte code
    initial begin
        {rst, ce, start, wide, page_write, slow} = 7'h60;
        mode = MODE_INHERENT;
        {pc_in, acc_a, acc_b, page_wdata} = '0;
        ptr = '{default: 16'h0000};
        for (int a = 0; a < 65536; a++) partner.mem[a] = 8'(rnd());
        repeat (3) @(negedge clk);
        rst = 1'b0;
        chk("page after reset", 16'h0000, {8'h00, page_base_register});
        page = 8'h00;
        for (int i = 0; i < 60; i++) begin
            if (i % 10 == 5) set_page(8'(rnd()));
            slow = 2'(rnd());
            op(mode_type'(i % 5), 16'(rnd()), i[3]);
        end
        $display("test plain modes ended");
        for (int i = 0; i < 280; i++) begin
            logic [31:0] x;
            logic [15:0] p;
            int          k;
            x = rnd();
            p = 16'(rnd());
            k = i % 14;
            {ptr[i % 4], acc_a, acc_b} = {x[31:16], 16'(rnd())};
            slow = x[3:2];
            partner.mem[p] = (k == 12) ? {1'b0, x[26:20]} : (k == 13) ? EXT_IND_POST
                : {1'b1, x[25:24], x[23] & (k != 0) & (k != 2), lows[k]};
            op(MODE_INDEXED, p, 1'b0);
        end
        $display("test indexed ended");
        start = 1'b0;
        @(negedge clk);
        // a frozen core must ignore a request until the enable returns
        {ce, start} = 2'b01;
        mode = MODE_INHERENT;
        repeat (2) @(negedge clk);
        chk("frozen done", 16'h0000, {15'h0000, done});
        ce = 1'b1;
        @(negedge clk);
        chk("thawed done", 16'h0001, {15'h0000, done});
        // a reset in mid-run must clear a page base that was written
        set_page(8'hA5);
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        chk("page after second reset", 16'h0000, {8'h00, page_base_register});
        $display("test enable and reset ended");
        finish_test();
    end
endmodule
